// ### hw/sar_seq_pkg.sv
// Constants and types shared by the conversion sequencer design.
// Assumes a 200 MHz system clock; converter clock arrives as a pin.
package sar_seq_pkg;
  localparam int RESULT_W = 8;
  localparam int DIV_W = 4;
  localparam logic [DIV_W-1:0] DIV_LAST = 4'hF;          // Divide by 16
  localparam logic [DIV_W-1:0] DIV_HALF = 4'h7;          // Mid phase, first step of each period
  localparam logic [3:0] SET_PULSE_LEN = 4'h8;           // Done set pulse, external periods
  localparam logic [RESULT_W-1:0] RESULT_ZERO = 8'h00;
  localparam logic [RESULT_W-1:0] RESULT_FULL = 8'hFF;
  localparam logic [RESULT_W-1:0] HEAD_ONE = 8'h80;
  localparam logic [RESULT_W:0] SHIFT_CLEAR = 9'h000;
  localparam logic [RESULT_W:0] SHIFT_HEAD = 9'h001;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_HOLD = 3'b010,
    ST_RUN = 3'b100
  } seq_state_t;
endpackage

// ### hw/pin_sync.sv
// Two-flop synchroniser for a group of pin inputs.
// Assumes inputs are asynchronous to sys_clk_in.
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  logic [W-1:0] meta_reg;

  // First stage read only by second stage
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      meta_reg <= INIT;
      q_out <= INIT;
    end else begin
      meta_reg <= d_in;
      q_out <= meta_reg;
    end
  end
endmodule

// ### hw/ext_clk_divider.sv
// Divides the synchronised converter clock by 16 and flags phases.
// Assumes conv_clk_in is already synchronised to sys_clk_in.
`timescale 1ns/1ps
module ext_clk_divider
  import sar_seq_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic conv_clk_in,
  output logic ext_tick_out,
  output logic step_tick_out,
  output logic gate_tick_out
);
  logic last_clk_reg;
  logic [DIV_W-1:0] div_reg;

  // Rising edge of the external clock
  always_comb begin
    ext_tick_out = conv_clk_in && !last_clk_reg;
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      last_clk_reg <= 1'b0;
    end else begin
      last_clk_reg <= conv_clk_in;
    end
  end

  // Free-running divide by 16
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      div_reg <= '0;
    end else if (ext_tick_out) begin
      div_reg <= div_reg + 4'h1;
    end
  end

  always_comb begin
    step_tick_out = ext_tick_out && (div_reg == DIV_LAST);
    gate_tick_out = ext_tick_out && (div_reg == DIV_HALF);
  end
endmodule

// ### hw/sar_conversion_sequencer.sv
// Digital control of an 8-bit successive approximation converter.
// Assumes an external comparator input and an external converter clock pin.
// Function
// - Negative input at or above positive input yields result zero.
// - MSB first, eight comparisons, seventy-two external clocks from launch to latch.
// - Result latched to output, then done output falls; all ones is full scale.
// - New start during conversion aborts it and restarts.
// - Start strobe falling edge clears approximation register and shift stages.
// - Select and start both low holds reset state, no progress.
// - Conversion begins one to eight external clocks after release.
// - Start flop sets on select and start low; clock-gated clear after release.
// - Internal step clock steps on both halves of the divide-by-sixteen, every eight external clocks.
// - Done set pulse lasts eight external clocks, even while reading.
// - Free-run falling done restarts, releasing done output quickly.
// - Select and read low clear done flop and drive result.
`timescale 1ns/1ps
module sar_conversion_sequencer
  import sar_seq_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic conv_clk_in,
  input wire logic select_n_in,
  input wire logic start_n_in,
  input wire logic read_n_in,
  input wire logic comp_high_in,
  output logic [RESULT_W-1:0] trial_code_out,
  output logic conversion_done_n_out,
  output logic [RESULT_W-1:0] data_out,
  output logic [RESULT_W-1:0] data_oe_n_out,
  output logic busy_out
);
  logic clk_s;
  logic select_n_s;
  logic start_n_s;
  logic read_n_s;
  logic comp_s;
  logic ext_tick;
  logic step_tick;
  logic full_tick;
  logic half_tick;
  logic launch;
  logic [RESULT_W-1:0] under_test;
  logic start_n_last_reg;
  logic start_set;
  logic start_fall;
  logic read_en;
  logic start_flop_reg;
  logic start_token_flop_reg;
  logic [RESULT_W:0] shift_reg;
  logic [RESULT_W-1:0] approximation_register_reg;
  logic [RESULT_W-1:0] result_reg;
  logic done_flop_reg;
  logic [3:0] set_count_reg;
  logic read_oe_reg;
  seq_state_t state_reg;

  // Stage holding the token marks the bit under test, MSB at the head
  function automatic logic [RESULT_W-1:0] test_mask(input logic [RESULT_W:0] stages);
    logic [RESULT_W-1:0] mask;
    mask = RESULT_ZERO;
    for (int i = 0; i < RESULT_W; i++) begin
      mask[i] = stages[RESULT_W-1-i];
    end
    return mask;
  endfunction

  // Pins synchronised before use
  pin_sync #(.W(5), .INIT(5'h0E)) u_sync (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .d_in({conv_clk_in, select_n_in, start_n_in, read_n_in, comp_high_in}),
    .q_out({clk_s, select_n_s, start_n_s, read_n_s, comp_s})
  );

  // Internal sequencing clocks
  ext_clk_divider u_div (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .conv_clk_in(clk_s),
    .ext_tick_out(ext_tick),
    .step_tick_out(full_tick),
    .gate_tick_out(half_tick)
  );

  // Strobe decode
  always_comb begin
    start_set = !select_n_s && !start_n_s;
    start_fall = start_set && start_n_last_reg;
    read_en = !select_n_s && !read_n_s;
    // One step on each half of the divided clock, eight external clocks apart
    step_tick = full_tick || half_tick;
    // Released start goes at the very next step, so the wait stays within eight clocks
    launch = step_tick && start_flop_reg && start_token_flop_reg && !start_set;
    under_test = test_mask(shift_reg);
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      start_n_last_reg <= 1'b1;
    end else begin
      start_n_last_reg <= start_n_s || select_n_s;
    end
  end

  // Start flop: set by strobes, cleared by gated pulse once released
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      start_flop_reg <= 1'b0;
    end else if (start_set) begin
      start_flop_reg <= 1'b1;
    end else if (launch) begin
      start_flop_reg <= 1'b0;
    end
  end

  // Head stage loads a one while start flop is set
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      start_token_flop_reg <= 1'b0;
    end else if (!start_flop_reg) begin
      start_token_flop_reg <= 1'b0;
    end else begin
      start_token_flop_reg <= 1'b1;
    end
  end

  // Shift register walks the token across eight steps
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      shift_reg <= SHIFT_CLEAR;
    end else if (start_fall || start_set) begin
      shift_reg <= SHIFT_CLEAR;
    end else if (launch) begin
      shift_reg <= SHIFT_HEAD;
    end else if (start_flop_reg) begin
      shift_reg <= SHIFT_CLEAR;
    end else if (step_tick) begin
      shift_reg <= {shift_reg[RESULT_W-1:0], 1'b0};
    end
  end

  // Sequencer state
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_reg <= ST_IDLE;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (start_flop_reg) begin
            state_reg <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          if (launch) begin
            state_reg <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (start_set) begin
            state_reg <= ST_HOLD;
          end else if (step_tick && shift_reg[RESULT_W]) begin
            state_reg <= ST_IDLE;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // Successive approximation, MSB first
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      approximation_register_reg <= RESULT_ZERO;
    end else if (start_fall || start_flop_reg) begin
      approximation_register_reg <= RESULT_ZERO;
    end else if (step_tick && state_reg == ST_RUN) begin
      for (int i = 0; i < RESULT_W; i++) begin
        // Only the bit under test takes the comparator verdict
        if (under_test[i]) begin
          approximation_register_reg[i] <= comp_s;
        end
      end
    end
  end

  // Trial code to the ladder: kept bits plus bit under test
  always_comb begin
    trial_code_out = approximation_register_reg | under_test;
  end

  // Output latch loads as the token leaves the register
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      result_reg <= RESULT_ZERO;
    end else if (step_tick && state_reg == ST_RUN && shift_reg[RESULT_W] && !start_set) begin
      result_reg <= approximation_register_reg;
    end
  end

  // Done set pulse: eight external clocks after the latch loads
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      set_count_reg <= 4'h0;
    end else if (start_set) begin
      set_count_reg <= 4'h0;
    end else if (step_tick && state_reg == ST_RUN && shift_reg[RESULT_W]) begin
      set_count_reg <= SET_PULSE_LEN;
    end else if (ext_tick && set_count_reg != 4'h0) begin
      set_count_reg <= set_count_reg - 4'h1;
    end
  end

  // Done flop: set wins over read clear
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      done_flop_reg <= 1'b0;
    end else if (start_flop_reg || start_set) begin
      done_flop_reg <= 1'b0;
    end else if (set_count_reg != 4'h0) begin
      done_flop_reg <= 1'b1;
    end else if (read_en) begin
      done_flop_reg <= 1'b0;
    end
  end

  // Read path enable
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      read_oe_reg <= 1'b0;
    end else begin
      read_oe_reg <= read_en;
    end
  end

  // Pin outputs
  always_comb begin
    conversion_done_n_out = !done_flop_reg;
    data_out = result_reg;
    data_oe_n_out = read_oe_reg ? RESULT_ZERO : RESULT_FULL;
    busy_out = (state_reg != ST_IDLE);
  end
endmodule

// ### tb/analog_front_model.sv
// Comparator and ladder model facing the sequencer.
// Assumes the trial code settles well before each step samples it.
`timescale 1ns/1ps
module analog_front_model (
  input wire logic [7:0] level_in,
  input wire logic neg_above_in,
  input wire logic [7:0] trial_code_in,
  output logic comp_high_out
);
  // Input at or above the tap; a negative input on top never trips
  assign comp_high_out = !neg_above_in && (level_in >= trial_code_in);
endmodule

// ### tb/sar_seq_assertions.sv
// Port checker for the conversion sequencer.
// Assumes a converter clock near six system clocks per period.
`timescale 1ns/1ps
module sar_seq_checker (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic select_n_in,
  input wire logic start_n_in,
  input wire logic read_n_in,
  input wire logic [7:0] trial_code_out,
  input wire logic conversion_done_n_out,
  input wire logic [7:0] data_out,
  input wire logic [7:0] data_oe_n_out,
  input wire logic busy_out
);
  logic [7:0] low_cnt_reg;
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  // Cycles with done low, saturating
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      low_cnt_reg <= 8'h00;
    end else begin
      low_cnt_reg <= conversion_done_n_out ? 8'h00 : low_cnt_reg + {7'h00, low_cnt_reg != 8'hFF};
    end
  end
  // Strobe patterns
  sequence start_held; (!select_n_in && !start_n_in)[*5]; endsequence
  sequence read_held; (!select_n_in && !read_n_in)[*4]; endsequence
  sequence bus_idle; (select_n_in || read_n_in)[*4]; endsequence
  hold_quiet_a: assert property (start_held |-> conversion_done_n_out && $stable(trial_code_out))
    else $error("step taken while held");
  hold_clear_a: assert property (start_held |-> trial_code_out == 8'h00)
    else $error("trial not cleared");
  hold_busy_a: assert property (start_held |-> busy_out)
    else $error("start not taken");
  oe_on_a: assert property (read_held |-> data_oe_n_out == 8'h00)
    else $error("result not driven");
  oe_off_a: assert property (bus_idle |-> data_oe_n_out == 8'hFF)
    else $error("bus not released");
  latch_first_a: assert property ($fell(conversion_done_n_out) |-> $stable(data_out))
    else $error("result moved at done");
  done_stays_a: assert property ($fell(conversion_done_n_out) ##0 (start_n_in || select_n_in)[*7]
    |-> !conversion_done_n_out)
    else $error("done pulse too short");
  read_clear_a: assert property ((low_cnt_reg > 8'h3C && !select_n_in && !read_n_in)[*4]
    |-> conversion_done_n_out)
    else $error("read left done low");
endmodule
bind sar_conversion_sequencer sar_seq_checker chk_i (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
  .select_n_in(select_n_in), .start_n_in(start_n_in), .read_n_in(read_n_in),
  .trial_code_out(trial_code_out), .conversion_done_n_out(conversion_done_n_out),
  .data_out(data_out), .data_oe_n_out(data_oe_n_out), .busy_out(busy_out));

// ### tb/sar_conversion_sequencer_tb_top.sv
// Self-checking bench for the conversion sequencer.
// Assumes the comparator model and checker are compiled first.
`timescale 1ns/1ps
module sar_conversion_sequencer_tb_top;
  logic sys_clk_in = 0, conv_clk = 0, rst_in = 1, select_n = 1, start_n = 1, read_n = 1;
  logic free_run = 0, neg_above = 0, comp_high, done_n, busy;
  logic [7:0] level = 8'h00, trial, data, oe_n;
  int n_errors = 0, check_count = 0, cycles = 0, ext_cnt = 0, mark, w;
  // Clocks; the converter clock drifts against the system clock
  always #2.5 sys_clk_in = ~sys_clk_in;
  always #15.3 conv_clk = ~conv_clk;
  always @(posedge conv_clk) ext_cnt++;
  // Hang guard
  always @(posedge sys_clk_in) begin
    cycles++;
    if (cycles == 40000) begin
      n_errors++;
      finish_test();
    end
  end
  sar_conversion_sequencer DUT (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .conv_clk_in(conv_clk),
    .select_n_in(select_n), .start_n_in(free_run ? done_n : start_n), .read_n_in(read_n),
    .comp_high_in(comp_high), .trial_code_out(trial), .conversion_done_n_out(done_n),
    .data_out(data), .data_oe_n_out(oe_n), .busy_out(busy));
  analog_front_model AFE (.level_in(level), .neg_above_in(neg_above), .trial_code_in(trial),
    .comp_high_out(comp_high));
  task step(input int n);
    repeat (n) @(posedge sys_clk_in);
    #1;
  endtask
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task wait_done();
    repeat (1500) if (done_n) step(1);
    chk({7'h00, done_n}, 8'h00);
  endtask
  // Start strobe of given width, then timed wait for done
  task convert(input int width);
    select_n = 0;
    start_n = 0;
    step(width);
    start_n = 1;
    mark = ext_cnt;
    repeat (600) if (trial === 8'h00) step(1);
    chk({7'h00, (ext_cnt - mark) inside {[0:8]}}, 8'h01);
    chk(trial, 8'h80);
    mark = ext_cnt;
    wait_done();
    chk({7'h00, (ext_cnt - mark) inside {[64:72]}}, 8'h01);
  endtask
  // Read after the set pulse: drive, clear done, then release
  task read_check(input logic [7:0] exp);
    step(80);
    chk({7'h00, busy}, 8'h00);
    read_n = 0;
    step(5);
    chk(oe_n, 8'h00);
    chk(data, exp);
    chk({7'h00, done_n}, 8'h01);
    read_n = 1;
    step(5);
    chk(oe_n, 8'hFF);
  endtask
  task t_levels();
    logic [7:0] lv [3] = '{8'hA5, 8'hFF, 8'h00};
    foreach (lv[i]) begin
      t_one(lv[i], 1'b0, 3);
    end
  endtask
  task t_one(input logic [7:0] v, input logic neg, input int width);
    level = v;
    neg_above = neg;
    convert(width);
    read_check(neg ? 8'h00 : v);
    neg_above = 0;
  endtask
  task t_abort();
    level = 8'h3C;
    start_n = 0;
    step(3);
    start_n = 1;
    step(200);
    chk({7'h00, busy}, 8'h01);
    chk({7'h00, done_n}, 8'h01);
    t_one(8'hC3, 1'b0, 3);
  endtask
  task t_read_through();
    level = 8'h81;
    read_n = 0;
    convert(3);
    step(20);
    chk({7'h00, done_n}, 8'h00);
    step(80);
    chk({7'h00, done_n}, 8'h01);
    read_n = 1;
  endtask
  task t_free_run();
    level = 8'h6E;
    start_n = 0;
    step(3);
    start_n = 1;
    free_run = 1;
    wait_done();
    w = 0;
    repeat (100) if (!done_n) begin
      w++;
      step(1);
    end
    chk({7'h00, w <= 12}, 8'h01);
    wait_done();
    chk(data, 8'h6E);
    free_run = 0;
  endtask
  task finish_test();
    if (n_errors == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    step(10);
    rst_in = 0;
    step(3);
    t_levels();
    t_one(8'hC3, 1'b1, 3);
    t_one(8'h5A, 1'b0, 400);
    t_abort();
    t_read_through();
    t_free_run();
    finish_test();
  end
endmodule
